//--- blc_core.sv
// blc_core: pulse-width dimming receiver of the backlight driver
// assumes pins come from outside the clock domain; reset is power-up
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
//
// Contract
// RULE1 - pwm dimming needs select low plus pulses
// RULE2 - brightness follows dimming input high duty
// RULE3 - on/off high or open lights backlight
// RULE4 - low over 50ms latches off until power
// RULE5 - host keeps high pulses at least 30us
// RULE6 - host keeps duty and width above minimum
// RULE7 - host holds select low when off
// RULE8 - dimming frequency odd multiple quarter frame
// RULE9 - minimum duty point referenced at 325Hz
// RULE10 - host prefers pwm against image noise
// RULE11 - host sets period and width by counters
module blc_core #(
    parameter int LOW_LIMIT = blc_pkg::LOW_LIMIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic pwm_dim_input_i,
    input wire logic backlight_on_ctrl_i,
    input wire logic dim_method_select_i,
    input wire logic [blc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [blc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [blc_pkg::DATA_W-1:0] rdata_o,
    output logic backlight_en_o,
    output logic pwm_mode_o,
    output logic [blc_pkg::DUTY_W-1:0] brightness_o,
    output logic shutdown_o
);
    import blc_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] dim_sync_reg;
    logic [2:0] on_sync_reg;
    logic [2:0] sel_sync_reg;
    logic dim_reg;
    logic on_reg;
    logic sel_reg;
    logic dim_next;
    logic on_next;
    logic sel_next;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dim_sync_reg <= 3'h0;
            on_sync_reg <= 3'h7;
            sel_sync_reg <= 3'h7;
        end else begin
            dim_sync_reg <= {dim_sync_reg[1:0], pwm_dim_input_i};
            on_sync_reg <= {on_sync_reg[1:0], backlight_on_ctrl_i};
            sel_sync_reg <= {sel_sync_reg[1:0], dim_method_select_i};
        end
    end

    // a change counts once stages two and three agree
    assign dim_next = (dim_sync_reg[1] == dim_sync_reg[2]) ?
        dim_sync_reg[2] : dim_reg;
    assign on_next = (on_sync_reg[1] == on_sync_reg[2]) ?
        on_sync_reg[2] : on_reg;
    assign sel_next = (sel_sync_reg[1] == sel_sync_reg[2]) ?
        sel_sync_reg[2] : sel_reg;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dim_reg <= 1'b0;
            on_reg <= 1'b1;
            sel_reg <= 1'b1;
        end else begin
            dim_reg <= dim_next;
            on_reg <= on_next;
            sel_reg <= sel_next;
        end
    end

    // ------------------------------------------------------------------
    // pulse measurement
    // ------------------------------------------------------------------
    logic dim_prev_reg;
    logic rise;
    logic fall;
    logic [CNT_W-1:0] per_cnt_reg;
    logic [CNT_W-1:0] hi_cnt_reg;
    logic [CNT_W-1:0] low_cnt_reg;
    logic [CNT_W-1:0] period_reg;
    logic [CNT_W-1:0] high_reg;
    logic [CNT_W-1:0] low_next;
    logic sat_per;
    logic pwm_sel;
    logic low_over;

    assign rise = dim_reg && !dim_prev_reg;
    assign fall = !dim_reg && dim_prev_reg;
    assign sat_per = &per_cnt_reg;
    // RULE1 pwm method select
    assign pwm_sel = !sel_reg;
    assign low_next = dim_reg ? '0 :
        ((low_cnt_reg == CNT_W'(LOW_LIMIT)) ? low_cnt_reg :
        low_cnt_reg + 1'b1);
    // RULE4 low time limit
    assign low_over = pwm_sel && on_reg &&
        (low_cnt_reg == CNT_W'(LOW_LIMIT));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dim_prev_reg <= 1'b0;
            per_cnt_reg <= '0;
            hi_cnt_reg <= '0;
            low_cnt_reg <= '0;
            period_reg <= '0;
            high_reg <= '0;
        end else begin
            dim_prev_reg <= dim_reg;
            low_cnt_reg <= low_next;
            per_cnt_reg <= rise ? CNT_W'(1) :
                (sat_per ? per_cnt_reg : per_cnt_reg + 1'b1);
            hi_cnt_reg <= rise ? CNT_W'(1) :
                (dim_reg ? hi_cnt_reg + 1'b1 : hi_cnt_reg);
            if (rise) begin
                period_reg <= per_cnt_reg;
            end
            if (fall) begin
                high_reg <= hi_cnt_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // phase tracking, shutdown latch and short pulse flag
    // ------------------------------------------------------------------
    blc_phase_t phase_reg;
    blc_phase_t phase_next;
    logic latched_reg;
    logic short_reg;
    logic short_hit;

    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            BLC_IDLE: phase_next = dim_reg ? BLC_HIGH : BLC_IDLE;
            BLC_HIGH: phase_next = dim_reg ? BLC_HIGH : BLC_LOW;
            BLC_LOW: phase_next = dim_reg ? BLC_HIGH : BLC_LOW;
        endcase
    end

    // RULE5 flag short high pulse
    assign short_hit = fall && on_reg && pwm_sel &&
        (hi_cnt_reg < CNT_W'(MIN_HIGH_CYC));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_reg <= BLC_IDLE;
            latched_reg <= 1'b0;
            short_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            // RULE4 latch until power cycle
            if (low_over) begin
                latched_reg <= 1'b1;
            end
            // set wins; on/off low clears the short flag
            if (short_hit) begin
                short_reg <= 1'b1;
            end else if (!on_reg) begin
                short_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // duty to brightness
    // ------------------------------------------------------------------
    logic [CNT_W+DUTY_W-1:0] scaled;
    logic [CNT_W+DUTY_W-1:0] quot;
    logic [DUTY_W-1:0] duty;
    logic [DUTY_W-1:0] bright_next;
    logic lit_next;
    logic [DUTY_W-1:0] bright_reg;
    logic lit_reg;

    assign scaled = (CNT_W+DUTY_W)'(high_reg) * (CNT_W+DUTY_W)'(DUTY_FULL);
    assign quot = (period_reg == '0) ? '0 :
        scaled / (CNT_W+DUTY_W)'(period_reg);
    // RULE2 duty ratio to level, floored at minimum
    // RULE9 minimum duty floor
    assign duty = (quot >= (CNT_W+DUTY_W)'(DUTY_FULL)) ? DUTY_FULL :
        ((quot[DUTY_W-1:0] < DUTY_MIN) ? DUTY_MIN : quot[DUTY_W-1:0]);
    assign bright_next = !pwm_sel ? DUTY_FULL :
        ((phase_reg == BLC_IDLE) ? DUTY_MIN : duty);
    // RULE3 on/off control gates light
    assign lit_next = on_reg && !latched_reg && !low_over;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bright_reg <= 8'h00;
            lit_reg <= 1'b0;
        end else begin
            lit_reg <= lit_next;
            bright_reg <= lit_next ? bright_next : 8'h00;
        end
    end

    assign backlight_en_o = lit_reg;
    assign brightness_o = bright_reg;
    assign pwm_mode_o = pwm_sel;
    assign shutdown_o = latched_reg;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_reg;
    logic force_off_reg;

    assign status_word = DATA_W'({on_reg, pwm_sel, short_reg, lit_reg,
        latched_reg});
    assign rd_mux = (addr_i == REG_STATUS) ? status_word :
        (addr_i == REG_PERIOD) ? DATA_W'(period_reg) :
        (addr_i == REG_HIGH) ? DATA_W'(high_reg) :
        (addr_i == REG_DUTY) ? DATA_W'(bright_reg) :
        (addr_i == REG_CTRL) ? DATA_W'(force_off_reg) : READ_ZERO;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= '0;
            force_off_reg <= 1'b0;
        end else begin
            // ctrl bit0 masks every read
            rdata_reg <= (rd_i && !force_off_reg) ? rd_mux : '0;
            if (wr_i && addr_i == REG_CTRL) begin
                force_off_reg <= wdata_i[0];
            end
        end
    end

    assign rdata_o = rdata_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_latch_sticky: assert property (latched_reg |=> latched_reg) // RULE4
        else $error("shutdown latch released");
    a_latch_dark: assert property (latched_reg |=> !lit_reg) // RULE4
        else $error("backlight lit after shutdown");
    a_low_trip: assert property (low_over |=> latched_reg) // RULE4
        else $error("low limit did not latch");
    a_off_dark: assert property (!on_reg |=> !backlight_en_o) // RULE3
        else $error("backlight lit with on line low");
    a_on_lit: assert property // RULE3
        (on_reg && !latched_reg && !low_over |=> backlight_en_o)
        else $error("backlight dark with on line high");
    a_bright_floor: assert property // RULE2
        (lit_reg && pwm_sel |-> brightness_o >= DUTY_MIN)
        else $error("brightness below minimum");
    a_dc_full: assert property // RULE1
        (lit_next && !pwm_sel |=> brightness_o == DUTY_FULL)
        else $error("non-pwm mode not full");
    a_short_flag: assert property (short_hit |=> short_reg) // RULE5
        else $error("short pulse not flagged");
    a_dark_zero: assert property (!lit_reg |-> brightness_o == 8'h00) // RULE2
        else $error("brightness while dark");

    c_shutdown: cover property (low_over ##1 latched_reg);
    c_pwm_lit: cover property (pwm_sel && lit_reg && rise);
    c_short: cover property (short_hit);
    c_off_on: cover property (!on_reg ##1 on_reg);
    c_dc_mode: cover property (lit_reg && !pwm_sel);

    // ------------------------------------------------------------------
    // capture, latch, short flag, filter and read port checks
    // ------------------------------------------------------------------
    a_period_capture: assert property // RULE2
        (rise |=> period_reg == $past(per_cnt_reg))
        else $error("period not captured at rise");
    a_high_capture: assert property // RULE2
        (fall |=> high_reg == $past(hi_cnt_reg))
        else $error("high time not captured at fall");
    a_latch_cause: assert property // RULE4
        (!latched_reg && !low_over |=> !latched_reg)
        else $error("latch set without low limit");
    a_short_clear: assert property // RULE5
        (!on_reg && !short_hit |=> !short_reg)
        else $error("short flag kept with on line low");
    a_on_filter: assert property // RULE3
        ($changed(on_reg) |-> $past(on_sync_reg[1]) == $past(on_sync_reg[2]))
        else $error("on line change without agreement");

    a_read_idle: assert property
        (!rd_i |=> rdata_o == READ_ZERO)
        else $error("read data without read strobe");
    a_read_masked: assert property
        (rd_i && force_off_reg |=> rdata_o == READ_ZERO)
        else $error("masked read returned data");
endmodule

//--- blc_host_model.sv
// blc_host_model: host generator for the backlight dimming pins
// assumes period and high counts in clk_i cycles, set by the bench
`timescale 1ns/10ps
module blc_host_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic on_i,
    input wire logic pwm_i,
    input wire logic [23:0] period_i,
    input wire logic [23:0] high_i,
    output logic pwm_dim_input_o,
    output logic backlight_on_ctrl_o,
    output logic dim_method_select_o
);
    logic [23:0] cnt_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 24'h000000;
        end else if (!run_i || cnt_reg >= period_i - 24'h000001) begin
            cnt_reg <= 24'h000000;
        end else begin
            cnt_reg <= cnt_reg + 24'h000001;
        end
    end
    assign pwm_dim_input_o = run_i && (cnt_reg < high_i);
    assign backlight_on_ctrl_o = on_i;
    assign dim_method_select_o = on_i ? !pwm_i : 1'b0;
endmodule

//--- blc_pkg.sv
// blc_pkg: constants for the backlight luminance control block
// assumes a 20 MHz system clock
package blc_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int LOW_LIMIT_MS = 50;
    localparam int MIN_HIGH_US = 30;
    localparam int REF_FREQ_HZ = 325;
    // longest low time, rounded down to whole cycles
    localparam int LOW_LIMIT_CYC = (CLK_HZ / 1000) * LOW_LIMIT_MS;
    // least high width, rounded down to whole cycles
    localparam int MIN_HIGH_CYC = (CLK_HZ / 1000000) * MIN_HIGH_US;
    localparam int REF_PERIOD_CYC = CLK_HZ / REF_FREQ_HZ;
    // ------------------------------------------------------------------
    // widths and register map
    // ------------------------------------------------------------------
    localparam int CNT_W = 24;
    localparam int DUTY_W = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;
    localparam logic [DUTY_W-1:0] DUTY_MIN = 8'h03;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h1;
    localparam logic [ADDR_W-1:0] REG_HIGH = 4'h2;
    localparam logic [ADDR_W-1:0] REG_DUTY = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam int ST_LATCHED = 0;
    localparam int ST_LIT = 1;
    localparam int ST_SHORT = 2;
    localparam int ST_PWM = 3;
    localparam int ST_ONCTL = 4;
    typedef enum logic [1:0] {BLC_IDLE, BLC_HIGH, BLC_LOW} blc_phase_t;
endpackage

//--- tb.sv
// tb: self-checking bench for the backlight dimming receiver
// assumes blc_pkg, blc_core and blc_host_model are compiled first
`timescale 1ns/10ps
module tb;
    import blc_pkg::*;
    localparam int LIM = 200;
    logic clk_i, rst_b_i, wr_i, rd_i, run, on, pwm;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o;
    logic [23:0] per, hi;
    logic dim, onc, sel, backlight_en_o, pwm_mode_o, shutdown_o;
    logic [DUTY_W-1:0] brightness_o;
    int error_cnt, check_count, wait_k;
    blc_core #(.LOW_LIMIT(LIM)) i_blc_core (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .pwm_dim_input_i(dim),
        .backlight_on_ctrl_i(onc), .dim_method_select_i(sel),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .backlight_en_o(backlight_en_o),
        .pwm_mode_o(pwm_mode_o), .brightness_o(brightness_o),
        .shutdown_o(shutdown_o));
    blc_host_model i_blc_host_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .run_i(run), .on_i(on), .pwm_i(pwm), .period_i(per), .high_i(hi),
        .pwm_dim_input_o(dim), .backlight_on_ctrl_o(onc),
        .dim_method_select_o(sel));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                      input string nm);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(nm, rdata_o, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // host settings, then a settling time
    task automatic go(input int p, h, input logic o, m, input int n);
        @(posedge clk_i);
        per <= p[23:0];
        hi <= h[23:0];
        on <= o;
        pwm <= m;
        run <= 1'b1;
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    function automatic logic [31:0] duty(input int p, h);
        int d;
        d = h * 255 / p;
        if (d < 3) d = 3;
        if (d > 255) d = 255;
        return 32'(d);
    endfunction
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {wr_i, rd_i, run, on, pwm} = 5'h00;
        addr_i = 4'h0;
        wdata_i = 32'h0000_0000;
        per = 24'h0003E8;
        hi = 24'h000384;
        error_cnt = 0;
        check_count = 0;
        rst_b_i = 1'b0;
        repeat (20) @(posedge clk_i);
        chk("en_rst", {31'h0, backlight_en_o}, 32'h0);
        chk("shut_rst", {31'h0, shutdown_o}, 32'h0);
        rst_b_i <= 1'b1;
        go(1000, 900, 1'b1, 1'b1, 4000);
        chk("en_on", {31'h0, backlight_en_o}, 32'h1);
        chk("mode_on", {31'h0, pwm_mode_o}, 32'h1);
        chk("bright_a", {24'h0, brightness_o}, duty(1000, 900));
        rd(REG_STATUS, 32'h0000_001A, "status_on");
        rd(REG_PERIOD, 32'h0000_03E8, "period");
        rd(REG_HIGH, 32'h0000_0384, "high");
        rd(4'hF, READ_ZERO, "unmapped");
        wr(REG_CTRL, 32'h0000_0001);
        rd(REG_STATUS, READ_ZERO, "masked");
        wr(REG_CTRL, 32'h0000_0000);
        go(700, 600, 1'b1, 1'b1, 4000);
        chk("bright_b", {24'h0, brightness_o}, duty(700, 600));
        rd(REG_DUTY, duty(700, 600), "duty_reg");
        go(700, 600, 1'b1, 1'b0, 40);
        chk("mode_off", {31'h0, pwm_mode_o}, 32'h0);
        chk("bright_nopwm", {24'h0, brightness_o}, 32'h0000_00FF);
        go(200, 100, 1'b1, 1'b1, 1000);
        rd(REG_STATUS, 32'h0000_001E, "status_short");
        go(200, 100, 1'b0, 1'b1, 40);
        chk("en_off", {31'h0, backlight_en_o}, 32'h0);
        chk("bright_off", {24'h0, brightness_o}, 32'h0);
        rd(REG_STATUS, 32'h0000_0008, "status_off");
        go(1000, 900, 1'b1, 1'b1, 4000);
        chk("en_again", {31'h0, backlight_en_o}, 32'h1);
        // cut the train in a low phase so no short pulse is made
        wait_k = 0;
        @(negedge clk_i);
        while (dim !== 1'b0 && wait_k < 2000) begin
            @(negedge clk_i);
            wait_k++;
        end
        if (wait_k >= 2000) begin
            error_cnt++;
        end
        @(posedge clk_i);
        run <= 1'b0;
        repeat (300) @(posedge clk_i);
        @(negedge clk_i);
        chk("shut_set", {31'h0, shutdown_o}, 32'h1);
        chk("en_latched", {31'h0, backlight_en_o}, 32'h0);
        go(1000, 900, 1'b1, 1'b1, 4000);
        chk("en_stays", {31'h0, backlight_en_o}, 32'h0);
        rd(REG_STATUS, 32'h0000_0019, "status_latch");
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4000) @(posedge clk_i);
        @(negedge clk_i);
        chk("shut_clear", {31'h0, shutdown_o}, 32'h0);
        chk("en_power", {31'h0, backlight_en_o}, 32'h1);
        close_out();
    end
endmodule
